// >>> design/timer_compare_consts.vh
// Register offset, field positions, reset values and pin-action codes of the compare status block
`ifndef TIMER_COMPARE_CONSTS_VH
`define TIMER_COMPARE_CONSTS_VH
`define STATUS_REG_OFFSET 4'h0
`define MATCH_B_BIT 7
`define MATCH_A_BIT 6
`define WRAP_BIT 5
`define RESERVED_BIT 4
`define SEL_B_HI 3
`define SEL_B_LO 2
`define SEL_A_HI 1
`define SEL_A_LO 0
`define RESERVED_READ 1'b1
`define FLAG_RESET 1'b0
`define SEL_RESET 2'h0
`define PIN_RESET 1'b0
`define COUNT_MAX 8'hFF
`define COUNT_MIN 8'h00
`define ACT_KEEP 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_PAD 24'h000000
`endif

// >>> design/match_detect.v
// Compare-match event detector for one compare constant
`timescale 1ns/1ps
`default_nettype none
module match_detect #(
  parameter COUNT_W = 8
) (
  input wire [COUNT_W-1:0] running_count,
  input wire [COUNT_W-1:0] compare_constant,
  input wire count_step,
  output wire match_event
);
  // Qualified by the count step so a stalled counter does not toggle the pin every cycle
  assign match_event = count_step && (running_count == compare_constant);
endmodule
`default_nettype wire

// >>> design/timer_compare_status_output.v
// Timer compare-match status register and compare output pin, AXI4-Lite slave
// Functional notes
// - Set match flag A on count equal A
// - Clear flag A: read one, write zero
// - Set wrap flag on FF to 00
// - Clear wrap flag: read one, write zero
// - Bit 4 reads one, ignores writes
// - Match B drives pin per bits 3:2
// - Match A drives pin per bits 1:0
// - Flags and selects reset to zero, selects writable
// - Set flag B on match B, same clear
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_consts.vh"
module timer_compare_status_output #(
  parameter COUNT_W = 8,
  parameter ADDR_W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [COUNT_W-1:0] running_count,
  input wire [COUNT_W-1:0] compare_constant_a,
  input wire [COUNT_W-1:0] compare_constant_b,
  input wire count_step,
  output reg compare_output_pin,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg match_flag_a_q;
  reg match_flag_b_q;
  reg wrap_flag_q;
  reg [1:0] out_select_a_q;
  reg [1:0] out_select_b_q;
  reg [2:0] arm_q;
  reg [COUNT_W-1:0] prev_count_q;
  reg aw_have_q;
  reg w_have_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire match_a;
  wire match_b;
  wire wrap_event;
  wire wr_fire;
  wire wr_hit;
  wire rd_fire;
  wire rd_hit;
  wire [7:0] status_value;
  reg pin_d;

  match_detect #(.COUNT_W(COUNT_W)) detect_a (
    .running_count(running_count),
    .compare_constant(compare_constant_a),
    .count_step(count_step),
    .match_event(match_a)
  );

  match_detect #(.COUNT_W(COUNT_W)) detect_b (
    .running_count(running_count),
    .compare_constant(compare_constant_b),
    .count_step(count_step),
    .match_event(match_b)
  );

  assign wrap_event = count_step && (prev_count_q == `COUNT_MAX) &&
                      (running_count == `COUNT_MIN);

  assign status_value = {match_flag_b_q, match_flag_a_q, wrap_flag_q, `RESERVED_READ,
                         out_select_b_q, out_select_a_q};

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = wr_fire && (awaddr_q == `STATUS_REG_OFFSET) && wstrb_q[0];
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hit = rd_fire && (s_axi_araddr == `STATUS_REG_OFFSET);

  // B is applied first so that A's action is applied on top of B's result when both match in the same step
  always @* begin
    pin_d = compare_output_pin;
    if (match_b) begin
      case (out_select_b_q)
        `ACT_KEEP: pin_d = pin_d;
        `ACT_LOW: pin_d = 1'b0;
        `ACT_HIGH: pin_d = 1'b1;
        `ACT_TOGGLE: pin_d = !pin_d;
        default: pin_d = pin_d;
      endcase
    end
    if (match_a) begin
      case (out_select_a_q)
        `ACT_KEEP: pin_d = pin_d;
        `ACT_LOW: pin_d = 1'b0;
        `ACT_HIGH: pin_d = 1'b1;
        `ACT_TOGGLE: pin_d = !pin_d;
        default: pin_d = pin_d;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_count_q <= `COUNT_MIN;
      compare_output_pin <= `PIN_RESET;
    end else begin
      if (count_step) begin
        prev_count_q <= running_count;
      end
      compare_output_pin <= pin_d;
    end
  end

  // Status flags: a clearing write needs an earlier read of one; set events beat the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      match_flag_a_q <= `FLAG_RESET;
      match_flag_b_q <= `FLAG_RESET;
      wrap_flag_q <= `FLAG_RESET;
      out_select_a_q <= `SEL_RESET;
      out_select_b_q <= `SEL_RESET;
      arm_q <= 3'h0;
    end else begin
      if (rd_hit) begin
        arm_q <= arm_q | {match_flag_b_q, match_flag_a_q, wrap_flag_q};
      end
      if (wr_hit) begin
        // Any write to the register with the low byte lane on consumes the arming read
        arm_q <= 3'h0;
        out_select_a_q <= wdata_q[`SEL_A_HI:`SEL_A_LO];
        out_select_b_q <= wdata_q[`SEL_B_HI:`SEL_B_LO];
        if (arm_q[2] && !wdata_q[`MATCH_B_BIT]) begin
          match_flag_b_q <= 1'b0;
        end
        if (arm_q[1] && !wdata_q[`MATCH_A_BIT]) begin
          match_flag_a_q <= 1'b0;
        end
        if (arm_q[0] && !wdata_q[`WRAP_BIT]) begin
          wrap_flag_q <= 1'b0;
        end
      end
      if (match_b) begin
        match_flag_b_q <= 1'b1;
      end
      if (match_a) begin
        match_flag_a_q <= 1'b1;
      end
      if (wrap_event) begin
        wrap_flag_q <= 1'b1;
      end
    end
  end

  // Write channels are taken independently; the response waits for both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `STATUS_REG_OFFSET) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? {`DATA_PAD, status_value} : 32'h00000000;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/timer_compare_checker.sv
// Port-level assertions for the compare status block
`timescale 1ns/1ps
`default_nettype none
module timer_compare_checker (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] running_count,
  input wire [7:0] compare_constant_a,
  input wire [7:0] compare_constant_b,
  input wire count_step,
  input wire compare_output_pin,
  input wire [3:0] s_axi_awaddr,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire hit_a = count_step && running_count == compare_constant_a;
  wire hit_b = count_step && running_count == compare_constant_b;
  wire rd_ok = s_axi_rvalid && s_axi_rresp == 2'h0;
  reg [3:0] sel_q;
  reg [1:0] seen_q;
  // Shadow taken at data acceptance; counts must stay still around writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= 4'h0;
      seen_q <= 2'h0;
    end else begin
      seen_q <= seen_q | {hit_b, hit_a};
      // A write whose low byte lane is off leaves the selects alone
      if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
        sel_q <= s_axi_wdata[3:0];
    end
  end
  a_low_on_a: assert property (hit_a && sel_q[1:0] == 2'h1 |=> !compare_output_pin)
    else $error("pin not low");
  a_high_on_a: assert property (hit_a && sel_q[1:0] == 2'h2 |=> compare_output_pin)
    else $error("pin not high");
  a_toggle_on_a: assert property (hit_a && !hit_b && sel_q[1:0] == 2'h3
    |=> compare_output_pin != $past(compare_output_pin)) else $error("no toggle");
  a_drive_on_b: assert property (hit_b && !hit_a && (sel_q[3] ^ sel_q[2])
    |=> compare_output_pin == $past(sel_q[3])) else $error("bad pin on B");
  a_pin_holds: assert property (!(hit_a && sel_q[1:0] != 2'h0)
    && !(hit_b && sel_q[3:2] != 2'h0) |=> $stable(compare_output_pin)) else $error("pin moved");
  a_reserved_one: assert property (rd_ok |-> s_axi_rdata[4]) else $error("bit 4 low");
  a_select_back: assert property (rd_ok |-> s_axi_rdata[3:0] == sel_q)
    else $error("select readback");
  a_flag_cause: assert property (rd_ok |-> (s_axi_rdata[7:6] & ~seen_q) == 2'h0)
    else $error("flag without match");
  cover property (hit_a && sel_q[1:0] == 2'h3);
  cover property (hit_b && sel_q[3:2] == 2'h2);
  cover property (rd_ok && s_axi_rdata[7:5] == 3'h7);
endmodule
bind timer_compare_status_output timer_compare_checker timer_compare_checker_i (.aclk, .aresetn,
  .running_count, .compare_constant_a, .compare_constant_b, .count_step, .compare_output_pin,
  .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid);
`default_nettype wire

// >>> sim/timer_compare_status_output_bench.sv
// Register and pin tests for the compare status block
`timescale 1ns/1ps
`default_nettype none
module timer_compare_status_output_bench;
  logic aclk = 1'b0, aresetn = 1'b0, count_step = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] running_count = 8'h00, compare_constant_a = 8'h40, compare_constant_b = 8'h80;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic compare_output_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] sels [4] = '{8'h09, 8'h00, 8'h06, 8'h0F};
  logic [3:0] pin_a = 4'b1110, pin_b = 4'b0011;
  int n_fail = 0, comparisons = 0, cyc = 0;
  timer_compare_status_output timer_compare_status_output_i (.aclk, .aresetn, .running_count,
    .compare_constant_a, .compare_constant_b, .count_step, .compare_output_pin, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial forever #50 aclk = ~aclk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic exp);
    comparisons++;
    if (compare_output_pin !== exp) begin
      n_fail++;
      $display("wrong value at %0t: pin %b expected %b", $time, compare_output_pin, exp);
    end
  endtask
  task automatic check_resp(input logic [1:0] exp);
    comparisons++;
    if (rsp !== exp) begin
      n_fail++;
      $display("wrong value at %0t: response %h expected %h", $time, rsp, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Step pulse lasts one cycle; the pin is looked at once its edge has landed
  task automatic step(input logic [7:0] c);
    @(posedge aclk);
    running_count <= c;
    count_step <= 1'b1;
    @(posedge aclk);
    count_step <= 1'b0;
    @(negedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    check(rdv, 32'h00000010);
    wr(4'h0, 8'hFF);
    check_resp(2'h0);
    rd(4'h0);
    check(rdv, 32'h0000001F);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, sels[i]);
      step(8'h40);
      check_pin(pin_a[i]);
      step(8'h80);
      check_pin(pin_b[i]);
    end
    step(8'hFF);
    step(8'h00);
    wr(4'h0, 8'h0F);
    rd(4'h0);
    check(rdv, 32'h000000FF);
    wr(4'h0, 8'h4F);
    rd(4'h0);
    check(rdv, 32'h0000005F);
    wr(4'h0, 8'h0F);
    rd(4'h0);
    check(rdv, 32'h0000001F);
    wr(4'h4, 8'h00);
    check_resp(2'h2);
    rd(4'h4);
    check_resp(2'h2);
    check(rdv, 32'h00000000);
    // Low byte lane off: the write is answered but must not touch the register
    s_axi_wstrb <= 4'h0;
    wr(4'h0, 8'h00);
    s_axi_wstrb <= 4'hF;
    check_resp(2'h0);
    rd(4'h0);
    check(rdv, 32'h0000001F);
    step(8'h40);
    check_pin(1'b1);
    // Reset in mid-run must drop the pin, the flags and the selects again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    check(rdv, 32'h00000010);
    check_pin(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
